// File: include/host_port_defines.vh
// Constants for the application-side host bus port
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH
`define CLK_MHZ            100
`define RESET_MIN_NS       1000
`define RESET_MIN_CYC      ((`RESET_MIN_NS * `CLK_MHZ + 999) / 1000)
`define ADDR_EP0_RX        8'h00
`define ADDR_EP0_TX        8'h01
`define ADDR_EP1_FIFO      8'h02
`define ADDR_EP2_FIFO      8'h03
`define ADDR_EP3_TX        8'h04
`define ADDR_IRQ_STATUS    8'h08
`define ADDR_IRQ_ENABLE    8'h09
`define ADDR_POLARITY      8'h0a
`define ADDR_EP_DIR        8'h0b
`define ADDR_DMA_CTRL      8'h0c
`define ADDR_PKT_READY     8'h0d
`define ADDR_FIFO_FLAGS    8'h0e
`define ADDR_RETRY         8'h0f
`define ADDR_EP1_PAYLOAD   8'h10
`define POL_RESET          3'h0
`define IRQ_EN_RESET       8'h00
`define DMA_CTRL_RESET     8'h00
`define EP_DIR_RESET       8'h00
`define PAYLOAD_RESET      7'h40
`define IRQ_BIT_PKT_EP0    0
`define IRQ_BIT_PKT_EP1    1
`define IRQ_BIT_PKT_EP2    2
`define IRQ_BIT_PKT_EP3    3
`define IRQ_BIT_SETUP      4
`define IRQ_BIT_SUSPEND    5
`define POL_BIT_IRQ        0
`define POL_BIT_DMA_REQUEST_OUT       1
`define POL_BIT_DMA_GRANT_IN       2
`define DMA_BIT_EN         0
`define DMA_BIT_WIDE       1
`define DMA_BIT_SINGLE     2
`define DMA_BIT_DUALADDR   3
`endif

// File: core/ep_fifo.v
// Endpoint FIFO with packet retry and a two-entry output skid buffer
`timescale 1ns/100ps
`default_nettype none
module ep_fifo #(
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire         clock_i,
   input  wire         resetn_i,
   input  wire         wr_i,
   input  wire [7:0]   wdata_i,
   input  wire         rd_i,
   input  wire         retry_i,
   input  wire         flush_i,
   output wire [7:0]   rdata_o,
   output wire         empty_o,
   output wire         full_o,
   output wire [AW:0]  count_o
);
   reg  [7:0]  mem [0:DEPTH-1];
   reg  [AW:0] wp;
   reg  [AW:0] rp;
   reg  [AW:0] mark;
   reg  [7:0]  skid [0:1];
   reg  [1:0]  skid_n;
   wire        fill_valid;
   wire        fill_ready;
   ////////////////////////////////////////////////////////////////////
   // Store feeds a two-entry buffer; the reader stalls nothing
   assign fill_valid = (wp != rp);
   assign fill_ready = (skid_n != 2'd2);
   assign empty_o    = (wp == mark) && (skid_n == 2'd0);
   assign full_o     = (wp[AW] != mark[AW]) && (wp[AW-1:0] == mark[AW-1:0]);
   assign count_o    = wp - mark;
   assign rdata_o    = skid[0];
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wp     <= {(AW+1){1'b0}};
         rp     <= {(AW+1){1'b0}};
         mark   <= {(AW+1){1'b0}};
         skid_n <= 2'd0;
         skid[0] <= 8'h00;
         skid[1] <= 8'h00;
      end else if (flush_i) begin
         wp     <= {(AW+1){1'b0}};
         rp     <= {(AW+1){1'b0}};
         mark   <= {(AW+1){1'b0}};
         skid_n <= 2'd0;
      end else if (retry_i) begin
         // Each byte is kept until read, so rewinding refetches only the unread bytes
         rp     <= mark;
         skid_n <= 2'd0;
      end else begin
         if (wr_i && !full_o) begin
            mem[wp[AW-1:0]] <= wdata_i;
            wp <= wp + 1'b1;
         end
         if (rd_i && skid_n != 2'd0) begin
            mark <= mark + 1'b1;
         end
         if (rd_i && skid_n != 2'd0) begin
            skid[0] <= (skid_n == 2'd2) ? skid[1] : mem[rp[AW-1:0]];
            if (skid_n == 2'd1 && fill_valid) begin
               rp <= rp + 1'b1;
            end else begin
               skid_n <= skid_n - 2'd1;
            end
         end else if (fill_valid && fill_ready) begin
            if (skid_n == 2'd0) begin
               skid[0] <= mem[rp[AW-1:0]];
            end else begin
               skid[1] <= mem[rp[AW-1:0]];
            end
            rp     <= rp + 1'b1;
            skid_n <= skid_n + 2'd1;
         end
      end
   end
endmodule
`default_nettype wire

// File: core/host_bus_port.v
// Application-side host bus port: decode, strobes, FIFOs, interrupt, DMA
// Function
// - Upper data byte always travels on its own upper lines.
// - Mux select low: low lines carry data, address from separate inputs.
// - Mux select high: low lines carry address then data.
// - Address and select latched at latch-strobe trailing edge; ignored otherwise.
// - Accesses honoured only while chip select is low, or on grant in single-address DMA.
// - Read strobe low while selected drives read data out.
// - Write strobe low while selected writes addressed register or FIFO.
// - Interrupt asserted while any enabled source is pending.
// - Interrupt, request low-active and grant high-active at reset; programmable.
// - Grant gives endpoint 1 FIFO access without any address.
// - Active-low reset loads every register's default (payload 64), FIFO storage aside; hold at least one microsecond.
// - FIFOs: 8/8 control, 2x64 bulk ep1, 64 bulk ep2, 8 ep3.
// - Endpoints 1 and 2 direction set by register write.
// - Each FIFO shows full/empty and can rewind to its first unread byte.
// - Only endpoint 1 uses DMA; 8/16-bit, demand and single.
// - Demand mode holds request until whole packet moved.
// - Single mode drops request after each transfer.
// - Events: packet ready, setup ready, suspend.
// - Enable register masks each interrupt source.
// - Writing one to packet-ready ends an early endpoint 1 fill.
// - Single-address DMA ignores address and select; uses grant.
// - Dual-address DMA ignores grant; uses select and address.
`timescale 1ns/100ps
`default_nettype none
`include "host_port_defines.vh"
module host_bus_port (
   input  wire        clock_i,
   input  wire        resetn_i,
   input  wire        bus_mux_select_i,
   input  wire [7:0]  sep_addr_bus_i,
   input  wire [7:0]  muxed_low_bus_i,
   output reg  [7:0]  muxed_low_bus_o,
   output reg         muxed_low_bus_oe_o,
   input  wire [7:0]  upper_data_bus_i,
   output reg  [7:0]  upper_data_bus_o,
   output reg         upper_data_bus_oe_o,
   input  wire        chip_sel_n_i,
   input  wire        read_n_i,
   input  wire        write_n_i,
   input  wire        addr_latch_i,
   input  wire        dma_grant_in_i,
   output reg         irq_out_o,
   output reg         dma_request_out_o,
   input  wire        ep0_rx_byte_valid_i,
   input  wire [7:0]  ep0_rx_byte_i,
   input  wire        setup_ready_event_i,
   input  wire        suspend_event_i,
   input  wire        ep_rx_pkt_event_i,
   output reg  [5:0]  irq_pending_o
);
   // Two sync flops per input; read and write add an edge stage on the qualified level, the latch strobe on its raw level
   reg  [1:0]  s_cs;
   reg  [1:0]  s_rd;
   reg  [1:0]  s_wr;
   reg  [1:0]  s_ale;
   reg  [1:0]  s_ack;
   reg  [1:0]  s_mux;
   reg         ale_d;
   reg         rd_d;
   reg         wr_d;
   reg  [7:0]  lat_addr;
   reg         lat_cs_n;
   reg  [7:0]  irq_en;
   reg  [2:0]  pol;
   reg  [7:0]  dma_ctrl;
   reg  [7:0]  ep_dir;
   reg  [6:0]  payload;
   reg  [6:0]  ep1_xfer;
   reg         ep1_pkt_rdy;
   reg         hi_phase;
   reg  [5:0]  pend;
   reg  [4:0]  retry_pulse;
   reg  [7:0]  rdata_lo;
   reg  [7:0]  rdata_hi;
   wire        mux_mode;
   wire        grant;
   wire        single_addr;
   wire        dma_acc;
   wire [7:0]  addr;
   wire        cs_ok;
   wire        rd_lvl;
   wire        wr_lvl;
   wire        rd_fall;
   wire        wr_fall;
   wire [4:0]  f_wr;
   wire [4:0]  f_rd;
   wire [4:0]  f_empty;
   wire [4:0]  f_full;
   wire [39:0] f_rdata;
   wire [7:0]  f_wdata [0:4];
   wire [5:0]  raise;
   wire        wide;
   ////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; reset loads select, read and write strobes high, the rest (latch strobe included) low
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_cs  <= 2'b11;
         s_rd  <= 2'b11;
         s_wr  <= 2'b11;
         s_ale <= 2'b00;
         s_ack <= 2'b00;
         s_mux <= 2'b00;
      end else begin
         s_cs  <= {s_cs[0], chip_sel_n_i};
         s_rd  <= {s_rd[0], read_n_i};
         s_wr  <= {s_wr[0], write_n_i};
         s_ale <= {s_ale[0], addr_latch_i};
         s_ack <= {s_ack[0], dma_grant_in_i};
         s_mux <= {s_mux[0], bus_mux_select_i};
      end
   end
   assign mux_mode    = s_mux[1];
   assign grant       = s_ack[1] ^ pol[`POL_BIT_DMA_GRANT_IN];
   // addressing mode picks grant or select
   assign single_addr = dma_ctrl[`DMA_BIT_EN] && !dma_ctrl[`DMA_BIT_DUALADDR];
   assign dma_acc     = single_addr && grant;
   assign addr  = dma_acc ? `ADDR_EP1_FIFO : (mux_mode ? lat_addr : sep_addr_bus_i);
   assign cs_ok = dma_acc || (mux_mode ? !lat_cs_n : !s_cs[1]);
   assign rd_lvl  = cs_ok && !s_rd[1];
   assign wr_lvl  = cs_ok && !s_wr[1];
   assign rd_fall = rd_lvl && !rd_d;
   assign wr_fall = wr_lvl && !wr_d;
   assign wide    = dma_ctrl[`DMA_BIT_WIDE];
   ////////////////////////////////////////////////////////////////////
   // latch on trailing edge of address strobe, mux mode only
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ale_d    <= 1'b0;
         rd_d     <= 1'b0;
         wr_d     <= 1'b0;
         lat_addr <= 8'h00;
         lat_cs_n <= 1'b1;
      end else begin
         ale_d <= s_ale[1];
         rd_d  <= rd_lvl;
         wr_d  <= wr_lvl;
         if (mux_mode && ale_d && !s_ale[1]) begin
            lat_addr <= muxed_low_bus_i;
            lat_cs_n <= s_cs[1];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // five endpoint FIFOs, one generate loop
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : fifo_gen
         localparam DP = (g == 2) ? 128 : ((g == 3) ? 64 : 8);
         localparam AB = (g == 2) ? 7 : ((g == 3) ? 6 : 3);
         assign f_wdata[g] = (g == 0 && ep0_rx_byte_valid_i) ? ep0_rx_byte_i :
                             ((hi_phase && g == 2) ? upper_data_bus_i : muxed_low_bus_i);
         ep_fifo #(.DEPTH(DP), .AW(AB)) u_fifo (
            .clock_i  (clock_i),
            .resetn_i (resetn_i),
            .wr_i     (f_wr[g]),
            .wdata_i  (f_wdata[g]),
            .rd_i     (f_rd[g]),
            .retry_i  (retry_pulse[g]),
            .flush_i  (1'b0),
            .rdata_o  (f_rdata[8*g +: 8]),
            .empty_o  (f_empty[g]),
            .full_o   (f_full[g]),
            .count_o  ()
         );
      end
   endgenerate
   // write strobe edge writes the addressed FIFO
   assign f_wr[0] = ep0_rx_byte_valid_i;
   assign f_wr[1] = wr_fall && addr == `ADDR_EP0_TX;
   assign f_wr[2] = (wr_fall || (hi_phase && wr_lvl)) && addr == `ADDR_EP1_FIFO;
   assign f_wr[3] = wr_fall && addr == `ADDR_EP2_FIFO;
   assign f_wr[4] = wr_fall && addr == `ADDR_EP3_TX;
   assign f_rd[0] = rd_fall && addr == `ADDR_EP0_RX;
   assign f_rd[1] = 1'b0;
   assign f_rd[2] = (rd_fall || (hi_phase && rd_lvl)) && addr == `ADDR_EP1_FIFO;
   assign f_rd[3] = rd_fall && addr == `ADDR_EP2_FIFO;
   assign f_rd[4] = 1'b0;
   ////////////////////////////////////////////////////////////////////
   // event sources; set wins over clear
   assign raise = {suspend_event_i, setup_ready_event_i,
                   ep_rx_pkt_event_i && ep_dir[1],
                   ep_rx_pkt_event_i && !ep_dir[1],
                   ep1_pkt_rdy, ep0_rx_byte_valid_i};
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_en      <= `IRQ_EN_RESET;
         pol         <= `POL_RESET;
         dma_ctrl    <= `DMA_CTRL_RESET;
         ep_dir      <= `EP_DIR_RESET;
         payload     <= `PAYLOAD_RESET;
         ep1_xfer    <= 7'h00;
         ep1_pkt_rdy <= 1'b0;
         hi_phase    <= 1'b0;
         pend        <= 6'h00;
         retry_pulse <= 5'h00;
      end else begin
         retry_pulse <= 5'h00;
         // 16-bit single-address DMA moves the upper byte one cycle after the lower
         hi_phase <= wide && dma_acc && (wr_fall || rd_fall);
         if (wr_fall) begin
            case (addr)
               `ADDR_IRQ_ENABLE:  irq_en   <= muxed_low_bus_i;
               `ADDR_POLARITY:    pol      <= muxed_low_bus_i[2:0];
               `ADDR_EP_DIR:      ep_dir   <= muxed_low_bus_i;
               `ADDR_DMA_CTRL:    dma_ctrl <= muxed_low_bus_i;
               `ADDR_EP1_PAYLOAD: payload  <= muxed_low_bus_i[6:0];
               `ADDR_RETRY:       retry_pulse <= muxed_low_bus_i[4:0];
               default: ;
            endcase
         end
         // early packet close, or size reached
         if (wr_fall && addr == `ADDR_PKT_READY && muxed_low_bus_i[0]) begin
            ep1_pkt_rdy <= 1'b1;
         end else if (f_wr[2] && ep1_xfer + 7'd1 >= payload) begin
            ep1_pkt_rdy <= 1'b1;
         end else if (f_empty[2] && ep1_pkt_rdy && ep_dir[0]) begin
            ep1_pkt_rdy <= 1'b0;
         end
         if (f_wr[2] || f_rd[2]) begin
            ep1_xfer <= ep1_xfer + 7'd1;
         end else if (!dma_acc && !wr_lvl) begin
            ep1_xfer <= 7'h00;
         end
         pend <= raise | (pend & ~((wr_fall && addr == `ADDR_IRQ_STATUS) ?
                                   muxed_low_bus_i[5:0] : 6'h00));
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Read mux
   always @* begin
      rdata_lo = 8'h00;
      rdata_hi = 8'h00;
      case (addr)
         `ADDR_EP0_RX:     rdata_lo = f_rdata[7:0];
         `ADDR_EP1_FIFO:   begin
            rdata_lo = f_rdata[23:16];
            rdata_hi = wide ? f_rdata[23:16] : 8'h00;
         end
         `ADDR_EP2_FIFO:   rdata_lo = f_rdata[31:24];
         `ADDR_IRQ_STATUS: rdata_lo = {2'b00, pend};
         `ADDR_IRQ_ENABLE: rdata_lo = irq_en;
         `ADDR_POLARITY:   rdata_lo = {5'h00, pol};
         `ADDR_EP_DIR:     rdata_lo = ep_dir;
         `ADDR_DMA_CTRL:   rdata_lo = dma_ctrl;
         `ADDR_PKT_READY:  rdata_lo = {7'h00, ep1_pkt_rdy};
         `ADDR_EP1_PAYLOAD: rdata_lo = {1'b0, payload};
         `ADDR_FIFO_FLAGS: begin
            rdata_lo = {3'b000, f_empty};
            rdata_hi = {3'b000, f_full};
         end
         default: ;
      endcase
   end
   ////////////////////////////////////////////////////////////////////
   // drive both bytes while reading
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         muxed_low_bus_o     <= 8'h00;
         muxed_low_bus_oe_o  <= 1'b0;
         upper_data_bus_o    <= 8'h00;
         upper_data_bus_oe_o <= 1'b0;
         irq_out_o           <= 1'b1;
         dma_request_out_o   <= 1'b1;
         irq_pending_o       <= 6'h00;
      end else begin
         muxed_low_bus_oe_o  <= rd_lvl;
         upper_data_bus_oe_o <= rd_lvl;
         if (rd_fall) begin
            muxed_low_bus_o  <= rdata_lo;
            upper_data_bus_o <= rdata_hi;
         end else if (hi_phase && rd_lvl && addr == `ADDR_EP1_FIFO) begin
            upper_data_bus_o <= f_rdata[23:16];
         end
         irq_out_o <= ~(|(pend & irq_en[5:0])) ^ pol[`POL_BIT_IRQ];
         dma_request_out_o <= ~(dma_ctrl[`DMA_BIT_EN] && ep1_pkt_rdy && !f_empty[2] &&
                              !(dma_ctrl[`DMA_BIT_SINGLE] && (rd_lvl || wr_lvl)))
                              ^ pol[`POL_BIT_DMA_REQUEST_OUT];
         irq_pending_o <= pend;
      end
   end
endmodule
`default_nettype wire

// File: bench/host_bus_port_monitor.sv
// Pin-level checks for the host bus port
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_monitor (
   input wire logic       clock_i,
   input wire logic       resetn_i,
   input wire logic       bus_mux_select_i,
   input wire logic       chip_sel_n_i,
   input wire logic       read_n_i,
   input wire logic       write_n_i,
   input wire logic       dma_grant_in_i,
   input wire logic       muxed_low_bus_oe_o,
   input wire logic       upper_data_bus_oe_o,
   input wire logic       irq_out_o,
   input wire logic       dma_request_out_o,
   input wire logic       setup_ready_event_i,
   input wire logic       suspend_event_i,
   input wire logic [5:0] irq_pending_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////////
   property p_read_drives;
      muxed_low_bus_oe_o |-> !$past(read_n_i, 3) || !$past(read_n_i, 4);
   endproperty
   a_read_drives: assert property (p_read_drives)
      else $error("low bus driven without read strobe");
   property p_read_release;
      $rose(read_n_i) |-> ##[1:6] !muxed_low_bus_oe_o;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("low bus still driven after read");
   property p_upper_too;
      muxed_low_bus_oe_o |-> upper_data_bus_oe_o;
   endproperty
   a_upper_too: assert property (p_upper_too)
      else $error("upper byte not driven with lower byte");
   property p_unselected;
      (chip_sel_n_i && !dma_grant_in_i && !bus_mux_select_i) [*4] |=> !muxed_low_bus_oe_o;
   endproperty
   a_unselected: assert property (p_unselected)
      else $error("bus driven while not selected");
   property p_setup_event;
      setup_ready_event_i |-> ##[1:3] irq_pending_o[4];
   endproperty
   a_setup_event: assert property (p_setup_event)
      else $error("setup event not pending");
   property p_suspend_event;
      suspend_event_i |-> ##[1:3] irq_pending_o[5];
   endproperty
   a_suspend_event: assert property (p_suspend_event)
      else $error("suspend event not pending");
   property p_reset_idle;
      $rose(resetn_i) |-> irq_out_o && dma_request_out_o && !muxed_low_bus_oe_o;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs not idle after reset");
   property p_clear_needs_write;
      write_n_i [*8] |-> !$fell(irq_pending_o[5]);
   endproperty
   a_clear_needs_write: assert property (p_clear_needs_write)
      else $error("pending cleared without a write");
endmodule
bind host_bus_port host_bus_port_monitor u_mon (
   .clock_i(clock_i), .resetn_i(resetn_i), .bus_mux_select_i(bus_mux_select_i),
   .chip_sel_n_i(chip_sel_n_i), .read_n_i(read_n_i), .write_n_i(write_n_i),
   .dma_grant_in_i(dma_grant_in_i), .muxed_low_bus_oe_o(muxed_low_bus_oe_o),
   .upper_data_bus_oe_o(upper_data_bus_oe_o), .irq_out_o(irq_out_o),
   .dma_request_out_o(dma_request_out_o), .setup_ready_event_i(setup_ready_event_i),
   .suspend_event_i(suspend_event_i), .irq_pending_o(irq_pending_o)
);
`default_nettype wire

// File: bench/host_bus_model.sv
// Behavioural local microcontroller on the host bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   input  wire logic       clock_i,
   input  wire logic [7:0] low_in_i,
   output var  logic       mux_o,
   output var  logic [7:0] addr_o,
   output var  logic [7:0] low_o,
   output var  logic [7:0] upper_o,
   output var  logic       cs_n_o,
   output var  logic       rd_n_o,
   output var  logic       wr_n_o,
   output var  logic       latch_o
);
   initial begin
      {mux_o, latch_o} = 2'b00;
      {cs_n_o, rd_n_o, wr_n_o} = 3'b111;
      {addr_o, low_o, upper_o} = 24'hff0000;
   end
   task automatic set_mux(input logic m);
      @(negedge clock_i);
      mux_o = m;
      repeat (4) @(negedge clock_i);
   endtask
   task automatic access(input logic rd, input logic sel, input logic [7:0] addr,
                         input logic [7:0] wdat, output logic [7:0] rdat);
      @(negedge clock_i);
      cs_n_o = !sel;
      addr_o = mux_o ? 8'hff : addr;
      if (mux_o) begin
         low_o = addr;
         latch_o = 1'b1;
         repeat (3) @(negedge clock_i);
         latch_o = 1'b0;
         repeat (3) @(negedge clock_i);
      end
      // Released lines show the inverse so a stale value never passes
      low_o = rd ? ~low_o : wdat;
      upper_o = rd ? ~upper_o : 8'h00;
      rd_n_o = !rd;
      wr_n_o = rd;
      repeat (6) @(posedge clock_i);
      rdat = low_in_i;
      @(negedge clock_i);
      {cs_n_o, rd_n_o, wr_n_o} = 3'b111;
      low_o = ~low_o;
      repeat (4) @(negedge clock_i);
   endtask
endmodule
`default_nettype wire

// File: bench/usb_device_host_bus_port_tb.sv
// Self-checking bench for the host bus port
`timescale 1ns/100ps
`default_nettype none
`include "host_port_defines.vh"
module usb_device_host_bus_port_tb;
   logic       clock_i, resetn_i, grant, rx_valid, setup_ev, susp_ev, pkt_ev;
   logic [7:0] rx_byte, rv;
   int         fail_count, cmp_count, i;
   wire  [7:0] low_o, up_o, hlow, hup, addr, low_bus;
   wire        low_oe, up_oe, irq, dma_request_out, mux, cs_n, rd_n, wr_n, latch;
   wire  [5:0] pend;
   assign low_bus = low_oe ? low_o : hlow;
   host_bus_model u_host (.clock_i(clock_i), .low_in_i(low_bus), .mux_o(mux),
      .addr_o(addr), .low_o(hlow), .upper_o(hup), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .latch_o(latch));
   host_bus_port u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .bus_mux_select_i(mux),
      .sep_addr_bus_i(addr), .muxed_low_bus_i(low_bus), .muxed_low_bus_o(low_o),
      .muxed_low_bus_oe_o(low_oe), .upper_data_bus_i(up_oe ? up_o : hup),
      .upper_data_bus_o(up_o), .upper_data_bus_oe_o(up_oe), .chip_sel_n_i(cs_n),
      .read_n_i(rd_n), .write_n_i(wr_n), .addr_latch_i(latch), .dma_grant_in_i(grant),
      .irq_out_o(irq), .dma_request_out_o(dma_request_out), .ep0_rx_byte_valid_i(rx_valid),
      .ep0_rx_byte_i(rx_byte), .setup_ready_event_i(setup_ev),
      .suspend_event_i(susp_ev), .ep_rx_pkt_event_i(pkt_ev), .irq_pending_o(pend));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel = 1'b1);
      u_host.access(1'b0, sel, a, d, rv);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_host.access(1'b1, 1'b1, a, 8'h00, rv);
      check8(rv, exp);
   endtask
   task automatic pulse(input logic [2:0] sel);
      @(negedge clock_i);
      {pkt_ev, susp_ev, setup_ev} = sel;
      @(negedge clock_i);
      {pkt_ev, susp_ev, setup_ev} = 3'h0;
      repeat (4) @(negedge clock_i);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // stands in for the board clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // Generous bound: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (30000) @(posedge clock_i);
      fail_count++;
      report_and_stop();
   end
   initial begin
      {resetn_i, grant, rx_valid, setup_ev, susp_ev, pkt_ev} = 6'h00;
      {rx_byte, fail_count, cmp_count} = 0;
      // held for the 1 us minimum
      repeat (`RESET_MIN_CYC) @(negedge clock_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge clock_i);
      check8({irq, dma_request_out, low_oe}, 8'h06);
      rd_chk(`ADDR_IRQ_ENABLE, `IRQ_EN_RESET);
      rd_chk(`ADDR_POLARITY, {5'h00, `POL_RESET});
      rd_chk(`ADDR_DMA_CTRL, `DMA_CTRL_RESET);
      rd_chk(`ADDR_EP_DIR, `EP_DIR_RESET);
      rd_chk(`ADDR_EP1_PAYLOAD, {1'b0, `PAYLOAD_RESET});
      $display("test reset done");
      wr(`ADDR_IRQ_ENABLE, 8'h30);
      rd_chk(`ADDR_IRQ_ENABLE, 8'h30);
      wr(`ADDR_IRQ_ENABLE, 8'h0f, 1'b0);
      rd_chk(`ADDR_IRQ_ENABLE, 8'h30);
      wr(`ADDR_EP_DIR, 8'h03);
      rd_chk(`ADDR_EP_DIR, 8'h03);
      $display("test access done");
      wr(`ADDR_IRQ_ENABLE, 8'h10);
      pulse(3'h1);
      check8({irq, 1'b0, pend}, 8'h10);
      rd_chk(`ADDR_IRQ_STATUS, 8'h10);
      wr(`ADDR_IRQ_STATUS, 8'h10);
      check8({irq, 1'b0, pend}, 8'h80);
      pulse(3'h6);
      check8({irq, 6'h00, pend[5]}, 8'h81);
      wr(`ADDR_IRQ_STATUS, 8'h3f);
      wr(`ADDR_POLARITY, 8'h03);
      check8({irq, dma_request_out}, 8'h00);
      wr(`ADDR_IRQ_ENABLE, 8'h20);
      pulse(3'h2);
      check8({irq, dma_request_out}, 8'h02);
      wr(`ADDR_IRQ_STATUS, 8'h20);
      wr(`ADDR_POLARITY, 8'h00);
      check8({irq, dma_request_out}, 8'h03);
      $display("test interrupt done");
      u_host.set_mux(1'b1);
      wr(`ADDR_IRQ_ENABLE, 8'h21);
      rd_chk(`ADDR_IRQ_ENABLE, 8'h21);
      u_host.set_mux(1'b0);
      rd_chk(`ADDR_IRQ_ENABLE, 8'h21);
      $display("test mux done");
      for (i = 0; i < 8; i++) begin
         @(negedge clock_i);
         {rx_valid, rx_byte} = {1'b1, 8'ha0 + i[7:0]};
         @(negedge clock_i);
         rx_valid = 1'b0;
      end
      // Control receive FIFO full, all others empty; full flags ride the upper byte
      rd_chk(`ADDR_FIFO_FLAGS, 8'h1e);
      check8(up_o, 8'h01);
      // Host drains slowly, so the output buffer refills before every byte and never stalls
      for (i = 0; i < 8; i++) begin
         rd_chk(`ADDR_EP0_RX, 8'ha0 + i[7:0]);
      end
      rd_chk(`ADDR_FIFO_FLAGS, 8'h1f);
      check8(up_o, 8'h00);
      $display("test fifo done");
      // Grant alone fills endpoint 1; address and select are left idle
      wr(`ADDR_DMA_CTRL, 8'h01);
      grant = 1'b1;
      wr(8'hff, 8'h5a, 1'b0);
      wr(8'hff, 8'ha5, 1'b0);
      grant = 1'b0;
      wr(`ADDR_PKT_READY, 8'h01);
      check8({7'h00, dma_request_out}, 8'h00);
      grant = 1'b1;
      rd_chk(8'hff, 8'h5a);
      check8({7'h00, dma_request_out}, 8'h00);
      rd_chk(8'hff, 8'ha5);
      grant = 1'b0;
      check8({7'h00, dma_request_out}, 8'h01);
      $display("test dma done");
      report_and_stop();
   end
endmodule
`default_nettype wire
